// ===== logic/timer16_irq_defines.svh
// offsets, bit positions, reset values and mode codes for the timer interrupt flag block
`ifndef TIMER16_IRQ_DEFINES_SVH
`define TIMER16_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// data-space offsets
// ----------------------------------------------------------------------------
`define TIMER1_EVENT_FLAGS_OFS  8'h36
`define TIMER3_EVENT_FLAGS_OFS  8'h38
`define TIMER4_EVENT_FLAGS_OFS  8'h39
`define TIMER1_IRQ_ENABLES_OFS  8'h6f
`define TIMER3_IRQ_ENABLES_OFS  8'h71
`define TIMER4_IRQ_ENABLES_OFS  8'h72

// ----------------------------------------------------------------------------
// i/o window
// ----------------------------------------------------------------------------
`define IO_SPACE_BASE           8'h20
`define EXT_IO_START            8'h60

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CAPTURE_BIT             5
`define COMPARE_B_BIT           2
`define COMPARE_A_BIT           1
`define OVERFLOW_BIT            0
`define IMPLEMENTED_BITS        8'h27
`define EVENT_FLAGS_RESET       8'h00
`define IRQ_ENABLES_RESET       8'h00

// ----------------------------------------------------------------------------
// waveform mode codes
// ----------------------------------------------------------------------------
`define MODE_NORMAL             4'h0
`define MODE_CTC_COMPARE_TOP    4'h4
`define MODE_CTC_CAPTURE_TOP    4'hc

`endif

// ===== logic/timer16_irq_pkg.sv
// types shared by the timer interrupt flag block and its bench
`default_nettype none

package timer16_irq_pkg;

  // counter-side event strobes of one timer, one cycle each
  typedef struct packed {
    logic capture_event;
    logic counter_at_top;
    logic compare_a_match;
    logic compare_b_match;
    logic counter_overflow;
  } timer_events_type;

  // one line per vector, used for requests and for vector acknowledges
  typedef struct packed {
    logic capture;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } irq_lines_type;

  // load/store data-space access
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ds_req_type;

  // in/out instruction access, i/o address space
  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } io_req_type;

  typedef enum logic [2:0] {
    ACC_NONE    = 3'b001,
    ACC_FLAGS   = 3'b010,
    ACC_ENABLES = 3'b100
  } access_kind_type;

  typedef struct packed {
    access_kind_type kind;
    logic [1:0]      idx;
  } decode_type;

endpackage

`default_nettype wire

// ===== logic/timer16_irq_mask_flags.sv
// interrupt enable and event flag registers for three 16-bit timers
//
// Function
// - enable register holds capture bit 5, compare-B 2, compare-A 1, overflow 0.
// - request raised only when enable, global enable and flag are all set.
// - flag register uses the same bit positions as the enable register.
// - capture flag sets on a capture event from the capture pin.
// - in capture-as-top modes the capture flag sets when counter reaches top.
// - compare flags set in the cycle after counter equals compare value.
// - forced compare strobes never set a compare flag.
// - overflow flag sets on counter overflow, mode timing given by the counter.
// - executing a vector clears its flag automatically.
// - writing one to a flag bit clears that flag.
// - flags reachable by load/store and by i/o at offset minus 0x20.
// - third timer has an identical flag register at data offset 0x39.
`include "timer16_irq_defines.svh"
`default_nettype none

module timer16_irq_mask_flags
  import timer16_irq_pkg::*;
#(
  parameter int NUM_TIMERS = 3
) (
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  input  wire logic             global_irq_enable_i,
  input  wire ds_req_type       ds_req_i,
  output logic [7:0]            ds_rdata_o,
  input  wire io_req_type       io_req_i,
  output logic [7:0]            io_rdata_o,
  input  wire timer_events_type events_i               [NUM_TIMERS],
  input  wire logic [3:0]       waveform_mode_select_i [NUM_TIMERS],
  input  wire irq_lines_type    vector_ack_i           [NUM_TIMERS],
  output irq_lines_type         irq_req_o              [NUM_TIMERS]
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic decode_type decode_addr(input logic [7:0] a);
    decode_type d;
    d.kind = ACC_NONE;
    d.idx  = 2'd0;
    if (a == `TIMER1_EVENT_FLAGS_OFS) begin
      d.kind = ACC_FLAGS;
      d.idx  = 2'd0;
    end else if (a == `TIMER3_EVENT_FLAGS_OFS) begin
      d.kind = ACC_FLAGS;
      d.idx  = 2'd1;
    end else if (a == `TIMER4_EVENT_FLAGS_OFS) begin
      d.kind = ACC_FLAGS;
      d.idx  = 2'd2;
    end else if (a == `TIMER1_IRQ_ENABLES_OFS) begin
      d.kind = ACC_ENABLES;
      d.idx  = 2'd0;
    end else if (a == `TIMER3_IRQ_ENABLES_OFS) begin
      d.kind = ACC_ENABLES;
      d.idx  = 2'd1;
    end else if (a == `TIMER4_IRQ_ENABLES_OFS) begin
      d.kind = ACC_ENABLES;
      d.idx  = 2'd2;
    end
    return d;
  endfunction

  // modes 8, 10, 12 and 14 take the capture register as top
  function automatic logic capture_is_top(input logic [3:0] mode);
    return mode[3] && !mode[0];
  endfunction

  // vector lines to register bit positions
  function automatic logic [7:0] lines_to_bits(input irq_lines_type l);
    logic [7:0] b;
    b                 = 8'h00;
    b[`CAPTURE_BIT]   = l.capture;
    b[`COMPARE_B_BIT] = l.compare_b;
    b[`COMPARE_A_BIT] = l.compare_a;
    b[`OVERFLOW_BIT]  = l.overflow;
    return b;
  endfunction

  logic [7:0] flags_reg   [NUM_TIMERS];
  logic [7:0] enables_reg [NUM_TIMERS];
  logic [7:0] ds_rdata_reg;
  logic [7:0] io_rdata_reg;
  decode_type ds_dec;
  decode_type io_dec;
  logic [7:0] io_as_data_addr;

  // in/out sees only the lower window, so enables above it stay load/store only
  assign io_as_data_addr = {2'b00, io_req_i.addr} + `IO_SPACE_BASE;
  assign ds_dec          = decode_addr(ds_req_i.addr);
  assign io_dec          = decode_addr(io_as_data_addr);

  // --------------------------------------------------------------------------
  // per-timer flags and enables
  // --------------------------------------------------------------------------
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    logic [7:0] set_bits;
    logic [7:0] clear_bits;
    logic [7:0] flags_next;
    logic [7:0] enables_next;
    logic       ds_flag_hit;
    logic       io_flag_hit;
    logic       ds_enable_hit;
    logic       capture_set;

    assign ds_flag_hit   = ds_req_i.wr && (ds_dec.kind == ACC_FLAGS) &&
                           (ds_dec.idx == 2'(t));
    assign io_flag_hit   = io_req_i.wr && (io_dec.kind == ACC_FLAGS) &&
                           (io_dec.idx == 2'(t));
    assign ds_enable_hit = ds_req_i.wr && (ds_dec.kind == ACC_ENABLES) &&
                           (ds_dec.idx == 2'(t));

    // capture source follows the waveform mode
    assign capture_set = capture_is_top(waveform_mode_select_i[t]) ?
                         events_i[t].counter_at_top :
                         events_i[t].capture_event;

    always_comb begin
      set_bits                 = 8'h00;
      set_bits[`CAPTURE_BIT]   = capture_set;
      // match strobe lands in the flag at this edge, visible the next cycle
      set_bits[`COMPARE_B_BIT] = events_i[t].compare_b_match;
      set_bits[`COMPARE_A_BIT] = events_i[t].compare_a_match;
      // forced compare strobes never reach this block at all
      set_bits[`OVERFLOW_BIT]  = events_i[t].counter_overflow;
    end

    always_comb begin
      clear_bits = lines_to_bits(vector_ack_i[t]);
      if (ds_flag_hit) begin
        clear_bits = clear_bits | ds_req_i.wdata;
      end
      if (io_flag_hit) begin
        clear_bits = clear_bits | io_req_i.wdata;
      end
    end

    // zero bits in a write never clear, and a set in the same cycle wins
    assign flags_next = ((flags_reg[t] & ~clear_bits) | set_bits) &
                        `IMPLEMENTED_BITS;

    assign enables_next = ds_enable_hit ? (ds_req_i.wdata & `IMPLEMENTED_BITS) :
                          enables_reg[t];

    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        flags_reg[t] <= `EVENT_FLAGS_RESET;
      end else begin
        flags_reg[t] <= flags_next;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        enables_reg[t] <= `IRQ_ENABLES_RESET;
      end else begin
        enables_reg[t] <= enables_next;
      end
    end

    // request lines are combinational so the core sees a flag at once
    always_comb begin
      irq_req_o[t].capture   = global_irq_enable_i &&
                               enables_reg[t][`CAPTURE_BIT] &&
                               flags_reg[t][`CAPTURE_BIT];
      irq_req_o[t].compare_b = global_irq_enable_i &&
                               enables_reg[t][`COMPARE_B_BIT] &&
                               flags_reg[t][`COMPARE_B_BIT];
      irq_req_o[t].compare_a = global_irq_enable_i &&
                               enables_reg[t][`COMPARE_A_BIT] &&
                               flags_reg[t][`COMPARE_A_BIT];
      irq_req_o[t].overflow  = global_irq_enable_i &&
                               enables_reg[t][`OVERFLOW_BIT] &&
                               flags_reg[t][`OVERFLOW_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  function automatic logic [7:0] read_value(input decode_type d,
                                            input logic [7:0] f0,
                                            input logic [7:0] f1,
                                            input logic [7:0] f2,
                                            input logic [7:0] e0,
                                            input logic [7:0] e1,
                                            input logic [7:0] e2);
    logic [7:0] v;
    v = 8'h00;
    if (d.kind == ACC_FLAGS) begin
      v = (d.idx == 2'd0) ? f0 : (d.idx == 2'd1) ? f1 : f2;
    end else if (d.kind == ACC_ENABLES) begin
      v = (d.idx == 2'd0) ? e0 : (d.idx == 2'd1) ? e1 : e2;
    end
    return v;
  endfunction

  // unmapped or idle reads return zero, unused bits always read zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ds_rdata_reg <= 8'h00;
    end else if (ds_req_i.rd) begin
      ds_rdata_reg <= read_value(ds_dec, flags_reg[0], flags_reg[1], flags_reg[2],
                                 enables_reg[0], enables_reg[1], enables_reg[2]);
    end else begin
      ds_rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      io_rdata_reg <= 8'h00;
    end else if (io_req_i.rd && (io_dec.kind == ACC_FLAGS)) begin
      io_rdata_reg <= read_value(io_dec, flags_reg[0], flags_reg[1], flags_reg[2],
                                 8'h00, 8'h00, 8'h00);
    end else begin
      io_rdata_reg <= 8'h00;
    end
  end

  assign ds_rdata_o = ds_rdata_reg;
  assign io_rdata_o = io_rdata_reg;

endmodule

`default_nettype wire

// ===== tb/timer16_irq_checker_assertions.sv
// port-level assertions for the timer interrupt flag block
`default_nettype none

module timer16_irq_checker
  import timer16_irq_pkg::*;
#(
  parameter int NUM_TIMERS = 3
) (
  input wire logic             ref_clk_i,
  input wire logic             srst_i,
  input wire logic             global_irq_enable_i,
  input wire ds_req_type       ds_req_i,
  input wire logic [7:0]       ds_rdata_o,
  input wire io_req_type       io_req_i,
  input wire logic [7:0]       io_rdata_o,
  input wire timer_events_type events_i               [NUM_TIMERS],
  input wire logic [3:0]       waveform_mode_select_i [NUM_TIMERS],
  input wire irq_lines_type    vector_ack_i           [NUM_TIMERS],
  input wire irq_lines_type    irq_req_o              [NUM_TIMERS]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic clr_a;
  // enable writes excluded too: they may drop the request without touching the flag
  assign clr_a = vector_ack_i[0].compare_a | (ds_req_i.wr & ds_req_i.addr == 8'h36 &
    ds_req_i.wdata[1]) | (io_req_i.wr & io_req_i.addr == 6'h16 & io_req_i.wdata[1]) |
    (ds_req_i.wr & ds_req_i.addr == 8'h6f);
  a_irq_needs_gie: assert property (!global_irq_enable_i |-> irq_req_o[0] == 4'h0)
    else $error("request without global enable");
  a_ds_unused_zero: assert property (ds_rdata_o[7:6] == 2'h0 && ds_rdata_o[4:3] == 2'h0)
    else $error("unused bit read nonzero");
  a_io_unused_zero: assert property (io_rdata_o[7:6] == 2'h0 && io_rdata_o[4:3] == 2'h0)
    else $error("unused io bit read nonzero");
  a_rdata_idle_zero: assert property (!ds_req_i.rd |=> ds_rdata_o == 8'h00)
    else $error("read data without read");
  a_io_ext_silent: assert property (io_req_i.rd && io_req_i.addr != 6'h16 &&
    io_req_i.addr != 6'h18 && io_req_i.addr != 6'h19 |=> io_rdata_o == 8'h00)
    else $error("io answered outside flag registers");
  a_ack_drops_irq: assert property (vector_ack_i[0].compare_a &&
    !events_i[0].compare_a_match |=> !irq_req_o[0].compare_a)
    else $error("vector execution left flag set");
  a_w1c_drops_irq: assert property (ds_req_i.wr && ds_req_i.addr == 8'h36 &&
    ds_req_i.wdata[0] && !events_i[0].counter_overflow |=> !irq_req_o[0].overflow)
    else $error("write one left flag set");
  a_flag_holds: assert property (irq_req_o[0].compare_a && !clr_a ##1
    global_irq_enable_i |-> irq_req_o[0].compare_a)
    else $error("flag lost without clear");
  c_ack: cover property (vector_ack_i[0].compare_a);
  c_race: cover property (events_i[1].compare_a_match && ds_req_i.wr);
  c_top: cover property (events_i[2].counter_at_top && waveform_mode_select_i[2] == 4'hc);
endmodule

bind timer16_irq_mask_flags timer16_irq_checker #(.NUM_TIMERS(NUM_TIMERS)) u_chk (
  .ref_clk_i, .srst_i, .global_irq_enable_i, .ds_req_i, .ds_rdata_o, .io_req_i, .io_rdata_o,
  .events_i, .waveform_mode_select_i, .vector_ack_i, .irq_req_o);

`default_nettype wire

// ===== tb/cpu_vector_model.sv
// cpu side model: executes one pending vector at a time
`default_nettype none

module cpu_vector_model
  import timer16_irq_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          ack_en_i,
  input  wire irq_lines_type irq_req_i,
  output var irq_lines_type  vector_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial vector_ack_o = '0;
  // lowest pending line only, one cycle, never a line that is not requested
  always @(negedge ref_clk_i) begin
    if (ack_en_i && vector_ack_o == '0)
      vector_ack_o <= irq_req_i & (~irq_req_i + 4'h1);
    else
      vector_ack_o <= '0;
  end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the timer interrupt flag block
`default_nettype none

module testbench
  import timer16_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic             gie = 1'b1;
  ds_req_type       ds = '0;
  io_req_type       io = '0;
  timer_events_type ev [3] = '{default: '0};
  logic [3:0]       mode [3] = '{default: 4'h0};
  logic             ack_en [3] = '{default: 1'b0};
  wire irq_lines_type ack [3];
  wire irq_lines_type irq [3];
  wire logic [7:0]  ds_q;
  wire logic [7:0]  io_q;
  logic [7:0]       fofs [3] = '{8'h36, 8'h38, 8'h39};
  logic [7:0]       eofs [3] = '{8'h6f, 8'h71, 8'h72};
  int               err_count = 0;
  int               total_checks = 0;
  int               cyc = 0;

  always #50 clk = ~clk;

  timer16_irq_mask_flags dut (.ref_clk_i(clk), .srst_i(srst), .global_irq_enable_i(gie),
    .ds_req_i(ds), .ds_rdata_o(ds_q), .io_req_i(io), .io_rdata_o(io_q), .events_i(ev),
    .waveform_mode_select_i(mode), .vector_ack_i(ack), .irq_req_o(irq));

  for (genvar g = 0; g < 3; g++) begin : g_cpu
    cpu_vector_model u_cpu (.ref_clk_i(clk), .ack_en_i(ack_en[g]), .irq_req_i(irq[g]),
      .vector_ack_o(ack[g]));
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // idle edge first, so back-to-back calls never reassign a strobe in one time step
  task automatic step(ds_req_type d, io_req_type i, int t, timer_events_type e);
    @(negedge clk);
    ds = d;
    io = i;
    ev[t] = e;
    @(negedge clk);
    ds = '0;
    io = '0;
    ev[t] = '0;
  endtask

  task automatic ds_wr(logic [7:0] a, logic [7:0] w);
    step('{a, 1'b1, 1'b0, w}, '0, 0, '0);
  endtask

  task automatic io_wr(logic [5:0] a, logic [7:0] w);
    step('0, '{a, 1'b1, 1'b0, w}, 0, '0);
  endtask

  task automatic ds_rd(logic [7:0] a, logic [7:0] e);
    step('{a, 1'b0, 1'b1, 8'h00}, '0, 0, '0);
    chk("ds_rdata", ds_q, e);
  endtask

  task automatic io_rd(logic [5:0] a, logic [7:0] e);
    step('0, '{a, 1'b0, 1'b1, 8'h00}, 0, '0);
    chk("io_rdata", io_q, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_enables();
    for (int i = 0; i < 3; i++) begin
      ds_rd(fofs[i], 8'h00);
      ds_rd(eofs[i], 8'h00);
      ds_wr(eofs[i], 8'hff);
      ds_rd(eofs[i], 8'h27);
    end
  endtask

  task automatic t_events();
    timer_events_type evb [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
    logic [7:0] flg [4] = '{8'h20, 8'h02, 8'h04, 8'h01};
    logic [7:0] exp;
    for (int t = 0; t < 3; t++) begin
      exp = 8'h00;
      for (int k = 0; k < 4; k++) begin
        step('0, '0, t, evb[k]);
        exp |= flg[k];
        ds_rd(fofs[t], exp);
      end
      io_rd(6'(fofs[t] - 8'h20), 8'h27);
      chk("irq_req", {4'h0, irq[t]}, 8'h0f);
    end
  endtask

  task automatic t_clear();
    ds_wr(8'h36, 8'h01);
    ds_rd(8'h36, 8'h26);
    ds_wr(8'h36, 8'h00);
    ds_rd(8'h36, 8'h26);
    io_wr(6'h16, 8'h26);
    io_rd(6'h16, 8'h00);
    step('{8'h38, 1'b1, 1'b0, 8'h02}, '0, 1, 5'h04);
    ds_rd(8'h38, 8'h27);
    ds_wr(8'h38, 8'h27);
    ds_rd(8'h38, 8'h00);
  endtask

  task automatic t_modes();
    ds_wr(8'h39, 8'h27);
    mode[2] = 4'hc;
    step('0, '0, 2, 5'h10);
    ds_rd(8'h39, 8'h00);
    step('0, '0, 2, 5'h08);
    ds_rd(8'h39, 8'h20);
    ds_wr(8'h39, 8'h20);
    mode[2] = 4'h4;
    step('0, '0, 2, 5'h08);
    ds_rd(8'h39, 8'h00);
    step('0, '0, 2, 5'h01);
    ds_rd(8'h39, 8'h01);
  endtask

  task automatic t_vector();
    gie = 1'b0;
    step('0, '0, 0, 5'h04);
    chk("irq_req", {4'h0, irq[0]}, 8'h00);
    gie = 1'b1;
    #1;
    chk("irq_req", {4'h0, irq[0]}, 8'h02);
    ack_en[0] = 1'b1;
    repeat (3) @(negedge clk);
    ack_en[0] = 1'b0;
    ds_rd(8'h36, 8'h00);
  endtask

  task automatic t_unmapped();
    ds_wr(8'h37, 8'hff);
    ds_rd(8'h37, 8'h00);
    io_rd(6'h17, 8'h00);
    io_rd(6'h11, 8'h00);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset_enables();
    t_events();
    t_clear();
    t_modes();
    t_vector();
    t_unmapped();
    wrap_up();
  end
endmodule

`default_nettype wire
